// File: rtl/bcp_regs.vh
`ifndef BCP_REGS_VH
`define BCP_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define BCP_OFS_DATA 4'h8
`define BCP_OFS_DIR 4'h9
`define BCP_OFS_ASSIGN 4'ha
`define BCP_OFS_RSV_LO 4'h4
`define BCP_OFS_RSV_HI 4'h7

// ****************************************
// Assignment register fields
// ****************************************
`define BCP_FREE_CYCLE_BIT 7
`define BCP_QUEUE_STATUS_BIT 5
`define BCP_BUS_CLOCK_OFF_BIT 4
`define BCP_LOW_STROBE_BIT 3
`define BCP_RW_PIN_BIT 2
`define BCP_ASSIGN_MASK 8'hbc
`define BCP_ONCE_MASK 8'hac
`define BCP_DIR_MASK 8'hfc

// ****************************************
// Mode codes {c, b, a}
// ****************************************
`define BCP_MODE_SPC_SINGLE 3'h0
`define BCP_MODE_EMU_NARROW 3'h1
`define BCP_MODE_SPC_TEST 3'h2
`define BCP_MODE_EMU_WIDE 3'h3
`define BCP_MODE_NRM_SINGLE 3'h4
`define BCP_MODE_NRM_NARROW 3'h5
`define BCP_MODE_PERIPH 3'h6
`define BCP_MODE_NRM_WIDE 3'h7

// ****************************************
// Reset values
// ****************************************
`define BCP_RST_DATA 8'h00
`define BCP_RST_DIR 8'h00
`define BCP_RST_ASSIGN 8'h00
`define BCP_RST_ASSIGN_NRM_SINGLE 8'h10
`define BCP_RST_ASSIGN_SPC_TEST 8'h2c
`define BCP_RST_ASSIGN_EMU 8'hac
`define BCP_RST_ASSIGN_OTHER 8'h00

`endif

// File: rtl/bcp_sync2.v
`timescale 1ns/1ps

// ****************************************
// Two flip-flop synchroniser
// ****************************************
module bcp_sync2
#(
    parameter WIDTH = 8
)
(
    input wire ref_clk,
    input wire resetn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;

always @(posedge ref_clk or negedge resetn)
begin
    if (!resetn)
    begin
        stage1 <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
        stage1 <= async_in;
        sync_out <= stage1;
    end
end

endmodule // bcp_sync2

// File: rtl/bcp_pin_cell.v
`timescale 1ns/1ps

// ****************************************
// One port pin: drive, read-back, pull
// ****************************************
module bcp_pin_cell
#(
    parameter OUT_OK = 1
)
(
    input wire ref_clk,
    input wire resetn,
    input wire alt_en,
    input wire alt_val,
    input wire dir,
    input wire dout,
    input wire pin_sync,
    input wire pull_ctrl,
    output reg pin_out,
    output reg pin_oe,
    output wire rd_bit,
    output reg pull_on
);

wire drive;
wire next_out;

// Alternate function beats direction
// Direction 1 drives, 0 listens
// Input-only pins never drive
assign drive = (OUT_OK != 0) && (alt_en || dir);
assign next_out = alt_en ? alt_val : dout;

// Direction picks latch or pin
assign rd_bit = ((OUT_OK != 0) && dir) ? dout : pin_sync;

always @(posedge ref_clk or negedge resetn)
begin
    if (!resetn)
    begin
        pin_out <= 1'b0;
        pin_oe <= 1'b0;
        pull_on <= 1'b0;
    end
    else
    begin
        pin_out <= next_out;
        pin_oe <= drive;
        pull_on <= pull_ctrl && !drive;
    end
end

endmodule // bcp_pin_cell

// File: rtl/bcp_port_e.v
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "bcp_regs.vh"

module bcp_port_e
#(
    parameter PULL_UP_POLARITY = 8'hff
)
(
    input wire ref_clk,
    input wire resetn,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    output wire ext_wr,
    output wire ext_rd,
    input wire [2:0] mode_sel,
    input wire emulate_port_e,
    input wire pull_ctrl,
    input wire free_cycle,
    input wire queue_status_hi,
    input wire queue_status_lo,
    input wire bus_clock,
    input wire low_byte_strobe,
    input wire rw_signal,
    input wire [7:0] pin_in,
    output wire [7:0] pin_out,
    output wire [7:0] pin_oe,
    output wire [7:0] pull_en,
    output wire [7:0] pull_up
);

// ****************************************
// Declarations
// ****************************************
reg [7:0] port_e_pin_data;
reg [7:0] port_e_pin_direction;
reg [7:0] port_e_function_assign;
reg init_pending;
reg once_done;
reg [7:0] next_assign;
reg [7:0] reset_assign;
reg [7:0] next_rdata;
wire [7:0] pin_sync;
wire [7:0] rd_bits;
wire [7:0] alt_en;
wire [7:0] alt_val;
wire normal_mode;
wire emu_mode;
wire expanded;
wire periph;
wire single_chip;
wire bus_mode;
wire narrow_normal;
wire data_mapped;
wire ctrl_mapped;
wire hit_data;
wire hit_dir;
wire hit_assign;
wire hit_rsv;
wire unmapped;
wire free_cycle_out_en;
wire queue_status_out_en;
wire bus_clock_pin_off;
wire low_byte_strobe_en;
wire rw_pin_en;

// ****************************************
// Mode decode
// ****************************************
assign normal_mode = mode_sel[2];
assign emu_mode = (mode_sel == `BCP_MODE_EMU_NARROW) ||
                  (mode_sel == `BCP_MODE_EMU_WIDE);
assign expanded = mode_sel[0];
assign periph = (mode_sel == `BCP_MODE_PERIPH);
assign single_chip = (mode_sel == `BCP_MODE_SPC_SINGLE) ||
                     (mode_sel == `BCP_MODE_NRM_SINGLE);
assign bus_mode = !single_chip && !periph;
assign narrow_normal = (mode_sel == `BCP_MODE_NRM_NARROW);

// ****************************************
// Address map
// ****************************************
assign data_mapped = !periph && !(expanded && emulate_port_e);
assign ctrl_mapped = !periph && !expanded;
assign hit_data = (addr == `BCP_OFS_DATA);
assign hit_dir = (addr == `BCP_OFS_DIR);
assign hit_assign = (addr == `BCP_OFS_ASSIGN);
assign hit_rsv = (addr >= `BCP_OFS_RSV_LO) && (addr <= `BCP_OFS_RSV_HI);
assign unmapped = (hit_data && !data_mapped) ||
                  ((hit_dir || hit_assign) && !ctrl_mapped) ||
                  (hit_rsv && periph);

// Unmapped accesses go out on the external bus
assign ext_wr = wr && unmapped;
assign ext_rd = rd && unmapped;

// ****************************************
// Mode-dependent reset value
// ****************************************
always @*
begin
    case (mode_sel)
        `BCP_MODE_NRM_SINGLE:
        begin
            reset_assign = `BCP_RST_ASSIGN_NRM_SINGLE;
        end
        `BCP_MODE_SPC_TEST:
        begin
            reset_assign = `BCP_RST_ASSIGN_SPC_TEST;
        end
        `BCP_MODE_EMU_NARROW, `BCP_MODE_EMU_WIDE:
        begin
            reset_assign = `BCP_RST_ASSIGN_EMU;
        end
        `BCP_MODE_NRM_NARROW, `BCP_MODE_NRM_WIDE:
        begin
            reset_assign = `BCP_RST_ASSIGN_OTHER;
        end
        default:
        begin
            reset_assign = `BCP_RST_ASSIGN_OTHER;
        end
    endcase
end

// ****************************************
// Assignment register write conditions
// ****************************************
always @*
begin
    next_assign = port_e_function_assign;
    if (emu_mode)
    begin
        next_assign = port_e_function_assign;
    end
    else if (normal_mode)
    begin
        next_assign[`BCP_BUS_CLOCK_OFF_BIT] =
            wdata[`BCP_BUS_CLOCK_OFF_BIT];
        if (!once_done)
        begin
            next_assign = (wdata & `BCP_ASSIGN_MASK);
        end
    end
    else
    begin
        next_assign = (wdata & `BCP_ASSIGN_MASK);
    end
end

// ****************************************
// Registers
// ****************************************
always @(posedge ref_clk or negedge resetn)
begin
    if (!resetn)
    begin
        port_e_pin_data <= `BCP_RST_DATA;
        port_e_pin_direction <= `BCP_RST_DIR;
        port_e_function_assign <= `BCP_RST_ASSIGN;
        init_pending <= 1'b1;
        once_done <= 1'b0;
    end
    else if (init_pending)
    begin
        // Mode strap sampled on the first edge after release
        port_e_function_assign <= reset_assign;
        init_pending <= 1'b0;
    end
    else if (wr)
    begin
        if (hit_data && data_mapped)
        begin
            port_e_pin_data <= wdata;
        end
        if (hit_dir && ctrl_mapped)
        begin
            port_e_pin_direction <= wdata & `BCP_DIR_MASK;
        end
        if (hit_assign && ctrl_mapped)
        begin
            port_e_function_assign <= next_assign;
            if (normal_mode)
            begin
                once_done <= 1'b1;
            end
        end
    end
end

// ****************************************
// Function enables
// ****************************************
assign free_cycle_out_en =
    port_e_function_assign[`BCP_FREE_CYCLE_BIT];
assign queue_status_out_en =
    port_e_function_assign[`BCP_QUEUE_STATUS_BIT];
assign bus_clock_pin_off =
    port_e_function_assign[`BCP_BUS_CLOCK_OFF_BIT];
assign low_byte_strobe_en =
    port_e_function_assign[`BCP_LOW_STROBE_BIT];
assign rw_pin_en = port_e_function_assign[`BCP_RW_PIN_BIT];

// Pin 4 clock works in every mode
assign alt_en[7] = free_cycle_out_en && bus_mode;
assign alt_en[6] = queue_status_out_en && bus_mode;
assign alt_en[5] = queue_status_out_en && bus_mode;
assign alt_en[4] = !bus_clock_pin_off;
assign alt_en[3] = low_byte_strobe_en && bus_mode && !narrow_normal;
assign alt_en[2] = rw_pin_en && bus_mode;
assign alt_en[1] = 1'b0;
assign alt_en[0] = 1'b0;

assign alt_val = {free_cycle, queue_status_hi, queue_status_lo,
                  bus_clock, low_byte_strobe, rw_signal, 2'b00};

// ****************************************
// Pins
// ****************************************
bcp_sync2 #(
    .WIDTH(8)
) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(pin_in),
    .sync_out(pin_sync)
);

genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pin
        // Pins 1:0 are input only
        bcp_pin_cell #(
            .OUT_OK((gi >= 2) ? 1 : 0)
        ) u_cell (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .alt_en(alt_en[gi]),
            .alt_val(alt_val[gi]),
            .dir(port_e_pin_direction[gi]),
            .dout(port_e_pin_data[gi]),
            .pin_sync(pin_sync[gi]),
            .pull_ctrl(pull_ctrl),
            .pin_out(pin_out[gi]),
            .pin_oe(pin_oe[gi]),
            .rd_bit(rd_bits[gi]),
            .pull_on(pull_en[gi])
        );
    end
endgenerate

// Interrupt pins pull up only
assign pull_up = {PULL_UP_POLARITY[7:2], 2'b11};

// ****************************************
// Read data
// ****************************************
always @*
begin
    next_rdata = 8'h00;
    if (rd)
    begin
        if (hit_data && data_mapped)
        begin
            // Pins 1:0 read their pins
            next_rdata = rd_bits;
        end
        else if (hit_dir && ctrl_mapped)
        begin
            next_rdata = port_e_pin_direction & `BCP_DIR_MASK;
        end
        else if (hit_assign && ctrl_mapped)
        begin
            next_rdata = port_e_function_assign &
                         `BCP_ASSIGN_MASK;
        end
        else
        begin
            next_rdata = 8'h00;
        end
    end
end

always @(posedge ref_clk or negedge resetn)
begin
    if (!resetn)
    begin
        rdata <= 8'h00;
    end
    else
    begin
        rdata <= next_rdata;
    end
end

endmodule // bcp_port_e

// File: sim/bcp_port_e_props.sv
`timescale 1ns/1ps
`include "bcp_regs.vh"

// ****************
// Port E checks
// ****************
module bcp_port_e_props
(
    input wire ref_clk,
    input wire resetn,
    input wire [3:0] addr,
    input wire rd,
    input wire [7:0] rdata,
    input wire ext_rd,
    input wire [2:0] mode_sel,
    input wire emulate_port_e,
    input wire pull_ctrl,
    input wire [7:0] pin_oe,
    input wire [7:0] pull_en,
    input wire [7:0] pull_up
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    wire periph = mode_sel == `BCP_MODE_PERIPH;

    irq_pin_input_a: assert property (pin_oe[1:0] == 2'b00)
        else $error("irq pin driven");
    irq_pull_up_a: assert property (pull_up[1:0] == 2'b11)
        else $error("irq pull not up");
    pull_inputs_a: assert property ($past(resetn, 2) &&
        $stable(pin_oe) && $stable(pull_ctrl) |->
        pull_en == (pull_ctrl ? ~pin_oe : 8'h00)) else $error("pull wrong");
    data_map_a: assert property (rd && addr == `BCP_OFS_DATA |->
        ext_rd == (periph || (mode_sel[0] && emulate_port_e)))
        else $error("data map wrong");
    ctrl_map_a: assert property (rd && (addr == `BCP_OFS_DIR ||
        addr == `BCP_OFS_ASSIGN) |-> ext_rd == (periph || mode_sel[0]))
        else $error("ctrl map wrong");
    unmapped_zero_a: assert property (rd && ext_rd |=>
        rdata == 8'h00) else $error("unmapped read not zero");
    reserved_zero_a: assert property (rd && addr >= `BCP_OFS_RSV_LO &&
        addr <= `BCP_OFS_RSV_HI |=> rdata == 8'h00)
        else $error("reserved read not zero");
    dir_low_zero_a: assert property (rd && addr == `BCP_OFS_DIR |=>
        rdata[1:0] == 2'b00) else $error("dir low bits set");
    assign_rsv_a: assert property (rd && addr == `BCP_OFS_ASSIGN |=>
        (rdata & 8'h43) == 8'h00) else $error("assign reserved set");
endmodule // bcp_port_e_props

bind bcp_port_e bcp_port_e_props u_props (.ref_clk, .resetn, .addr, .rd,
    .rdata, .ext_rd, .mode_sel, .emulate_port_e, .pull_ctrl, .pin_oe,
    .pull_en, .pull_up);

// File: sim/bcp_pin_partner.sv
`timescale 1ns/1ps

// ****************
// External pin devices
// ****************
module bcp_pin_partner
(
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire [7:0] ext_val,
    output wire [7:0] pin_in
);
    // Outside drivers back off where the port drives
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule // bcp_pin_partner

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "bcp_regs.vh"

// ****************
// Port E bench
// ****************
module testbench;
    logic ref_clk = 0, resetn = 0, wr = 0, rd = 0, emu = 0, pull = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, ev = 8'h00, d, dr, asg, fn, oe, d2, g, v, x;
    logic [7:0] rdata, pin_out, pin_oe, pull_en, pull_up, pin_in;
    logic [5:0] alt = 6'h00;
    logic [2:0] mode = 3'h0;
    logic [2:0] gm [4] = '{3'h4, 3'h2, 3'h0, 3'h3};
    logic ext_wr, ext_rd, e, u;
    int err_total = 0, check_count = 0, i, k;

    always #5 ref_clk = ~ref_clk;

    bcp_port_e DUT (.ref_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
        .ext_wr, .ext_rd, .mode_sel(mode), .emulate_port_e(emu),
        .pull_ctrl(pull), .free_cycle(alt[5]), .queue_status_hi(alt[4]),
        .queue_status_lo(alt[3]), .bus_clock(alt[2]),
        .low_byte_strobe(alt[1]), .rw_signal(alt[0]), .pin_in, .pin_out,
        .pin_oe, .pull_en, .pull_up);
    bcp_pin_partner peer (.pin_out, .pin_oe, .ext_val(ev), .pin_in);

    function automatic [7:0] fn_of(input [2:0] c, input [7:0] a);
        logic b;
        b = !(c == 3'h0 || c == 3'h4 || c == 3'h6);
        fn_of = {a[7] & b, {2{a[5] & b}}, ~a[4], a[3] & b & (c != 3'h5),
            a[2] & b, 2'b00};
    endfunction

    task automatic chk(input string w, input [7:0] p, input [7:0] q);
        check_count++;
        if (q !== p)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", w, p, q);
        end
    endtask

    task automatic wreg(input [3:0] a, input [7:0] val);
        addr <= a;
        wdata <= val;
        wr <= 1'b1;
        @(negedge ref_clk);
        e = ext_wr;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rreg(input [3:0] a);
        addr <= a;
        rd <= 1'b1;
        @(negedge ref_clk);
        e = ext_rd;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        g = rdata;
        @(posedge ref_clk);
    endtask

    task automatic do_reset(input [2:0] c);
        resetn <= 1'b0;
        mode <= c;
        emu <= 1'($urandom);
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        asg = c == 3'h4 ? 8'h10 : c == 3'h2 ? 8'h2c :
            (c[0] && !c[2]) ? 8'hac : 8'h00;
        d = 8'h00;
        dr = 8'h00;
    endtask

    task automatic pins(input [2:0] c);
        fn = fn_of(c, asg);
        oe = fn | (dr & 8'hfc & ~fn);
        d2 = (fn & {alt, 2'b00}) | (~fn & d);
        chk("pin_oe", oe, pin_oe);
        chk("pin_out", d2 & oe, pin_out & oe);
        chk("pull_en", pull ? ~oe : 8'h00, pull_en);
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #200000;
        err_total++;
        finish_test();
    end

    initial
    begin
        k = $urandom(86569);
        for (k = 0; k < 8; k++)
        begin
            do_reset(k[2:0]);
            repeat (2) @(posedge ref_clk);
            pins(k[2:0]);
            u = k == 6 || k[0];
            rreg(`BCP_OFS_DATA);
            chk("data ext", k == 6 || (k[0] && emu), e);
            rreg(`BCP_OFS_ASSIGN);
            chk("asg ext", u, e);
            chk("asg rst", u ? 8'h00 : asg, g);
            rreg(`BCP_OFS_DIR);
            chk("dir rst", 8'h00, g);
            chk("dir ext", u, e);
            i = 4 + $urandom % 4;
            wreg(i[3:0], 8'($urandom));
            chk("rsv ext", k == 6, e);
            rreg(i[3:0]);
            chk("rsv rd", 8'h00, g);
        end
        $display("test reset_map done");
        for (k = 0; k < 3; k++)
        begin
            do_reset(gm[k]);
            for (i = 0; i < 12; i++)
            begin
                d = 8'($urandom);
                dr = 8'($urandom);
                ev <= 8'($urandom);
                alt <= 6'($urandom);
                pull <= 1'($urandom);
                wreg(`BCP_OFS_DATA, d);
                wreg(`BCP_OFS_DIR, dr);
                repeat (3) @(posedge ref_clk);
                pins(gm[k]);
                x = dr & 8'hfc;
                rreg(`BCP_OFS_DATA);
                x = (x & d) | (~x & ((oe & d2) | (~oe & ev)));
                chk("data rd", x, g);
                rreg(`BCP_OFS_DIR);
                chk("dir rd", dr & 8'hfc, g);
            end
        end
        $display("test gpio done");
        for (k = 0; k < 4; k++)
        begin
            do_reset(gm[k]);
            for (i = 0; i < 3; i++)
            begin
                v = i == 1 ? 8'h00 : i == 0 ? 8'hff : 8'($urandom);
                wreg(`BCP_OFS_ASSIGN, v);
                chk("asg fwd", gm[k][0], e);
                u = !gm[k][2];
                if (!gm[k][0])
                    asg = (i == 0 || u) ? v & 8'hbc :
                        (asg & 8'hac) | (v & 8'h10);
                repeat (2) @(posedge ref_clk);
                pins(gm[k]);
                rreg(`BCP_OFS_ASSIGN);
                chk("asg rd", gm[k][0] ? 8'h00 : asg, g);
            end
        end
        $display("test assign done");
        finish_test();
    end
endmodule // testbench
